/* common/efom_cfg.svh */
`ifndef EFOM_CFG_SVH
`define EFOM_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define EFOM_ERRSEL_OFS   8'h00
`define EFOM_ERRMAP_OFS   8'h04
`define EFOM_FBMODE_OFS   8'h08
`define EFOM_FUNCMAP_OFS  8'h0c
`define EFOM_THR1_OFS     8'h10
`define EFOM_THR2_OFS     8'h14
`define EFOM_THRDIR_OFS   8'h18
`define EFOM_ERRSTAT_OFS  8'h1c
`define EFOM_FUNCSTAT_OFS 8'h20
`define EFOM_IRQSTAT_OFS  8'h24
`define EFOM_IRQCLR_OFS   8'h28
`define EFOM_IRQEN_OFS    8'h2c
`define EFOM_CHSTAT_OFS   8'h30

// ----------------------------------------------------------------
// Error source bits
// ----------------------------------------------------------------
`define EFOM_E_CMDBRK 0
`define EFOM_E_SC1    1
`define EFOM_E_SC2    2
`define EFOM_E_OPEN1  3
`define EFOM_E_OPEN2  4
`define EFOM_E_DEV    5
`define EFOM_E_THR    6
`define EFOM_CH1_MASK 7'h6b
`define EFOM_CH2_MASK 7'h75

// ----------------------------------------------------------------
// Function flag bits and routing field
// ----------------------------------------------------------------
`define EFOM_F_SOL1  0
`define EFOM_F_SOL2  1
`define EFOM_F_READY 2
`define EFOM_F_CMD2  3
`define EFOM_F_THR1  4
`define EFOM_F_THR2  5
`define EFOM_F_CTL2  6
`define EFOM_MAP_USED 3

// ----------------------------------------------------------------
// Reset values and fallback arithmetic
// ----------------------------------------------------------------
`define EFOM_ERRSEL_RST  7'h7f
`define EFOM_ERRMAP_RST  4'h0
`define EFOM_FUNCMAP_RST 28'h0000000
`define EFOM_THR_RST     16'h8000
`define EFOM_THRDIR_RST  2'h3
`define EFOM_IRQEN_RST   7'h00
`define EFOM_MID_NUM     18'h00002
`define EFOM_MID_DEN     18'h00003

`endif

/* common/efom_pkg.sv */
package efom_pkg;

   typedef logic [15:0] efom_amp_t;
   typedef logic [6:0]  efom_err_t;
   typedef logic [3:0]  efom_map_t;

   typedef enum logic [1:0] {
      FB_OFF,
      FB_SOL1,
      FB_SOL2,
      FB_BOTH
   } efom_fb_t;

   typedef struct packed {
      logic      open;
      logic      short_cct;
      logic      use_other;
      efom_amp_t drive;
      efom_amp_t imin;
      efom_amp_t imax;
   } efom_coil_t;

endpackage

/* hdl/efom_thresh.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Switching threshold comparator
// ----------------------------------------------------------------
module efom_thresh (
   input  wire efom_pkg::efom_amp_t sig_i,
   input  wire efom_pkg::efom_amp_t level_i,
   input  wire logic                rise_i,
   output logic                     beyond_o
);

   wire above;
   wire below;

   assign above    = sig_i > level_i;
   assign below    = sig_i < level_i;
   assign beyond_o = rise_i ? above : below;

endmodule

/* hdl/efom_top.sv */
`timescale 1ns/1ps
`include "efom_cfg.svh"

// ----------------------------------------------------------------
// Summary of operation
// - Cable breaks on command input, coil 1 and coil 2 are three error sources.
// - Short circuits on coil 1 and coil 2 are separate error sources.
// - Supply and fieldbus faults merge into one device error source.
// - A switching-threshold error is a further routable error source.
// - Error output goes active while any masked-in error is active.
// - An unassigned error output drives no pin.
// - Cable break applies the chosen fallback: off, coil 1, coil 2 or both.
// - A short circuit on either coil switches both coils off.
// - A fallback-driven coil gets imin plus two thirds of imax minus imin.
// - Live state of every error source is readable by software.
// - Each channel shows error while any of its errors is present, else ready.
// - Function flags route to own outputs; unassigned ones drive nothing.
// - Coil-active flag is set while that coil's output current is nonzero.
// - Second-command flag is set while command value two is selected.
// - Threshold flags are set while the signal is beyond level in set direction.
// - Control-swap flag is set while a channel uses another channel's value.
// ----------------------------------------------------------------
module efom_top #(
   parameter int N_DOUT = 8
) (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [31:0]          wb_dat_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic                 wb_we_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 cmd_break_i,
   input  wire efom_pkg::efom_coil_t coil1_i,
   input  wire efom_pkg::efom_coil_t coil2_i,
   input  wire logic                 supply_fault_i,
   input  wire logic                 bus_fault_i,
   input  wire logic                 thr_err_i,
   input  wire logic                 cmd2_sel_i,
   input  wire efom_pkg::efom_amp_t  thr_sig1_i,
   input  wire efom_pkg::efom_amp_t  thr_sig2_i,
   output efom_pkg::efom_amp_t       coil1_cur_o,
   output efom_pkg::efom_amp_t       coil2_cur_o,
   output logic                      fallback_o,
   output logic [1:0]                ch_err_o,
   output logic [1:0]                ch_rdy_o,
   output logic [N_DOUT-1:0]         dout_o,
   output logic                      irq_o
);

   generate
      if (N_DOUT < 1 || N_DOUT > 8) begin : g_bad_width
         $error("N_DOUT must lie between 1 and 8");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      merge = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
   endfunction

   function automatic logic [7:0] route(input efom_pkg::efom_map_t m,
                                        input logic               act);
      route = 8'h00;
      if (m[`EFOM_MAP_USED] && act) begin
         route[m[2:0]] = 1'b1;
      end
   endfunction

   // The span is widened so that doubling it cannot overflow.
   function automatic efom_pkg::efom_amp_t mid_cur(input efom_pkg::efom_amp_t lo,
                                                   input efom_pkg::efom_amp_t hi);
      logic [17:0] span;
      span = 18'h00000;
      if (hi > lo) begin
         span = {2'b00, hi - lo};
      end
      span = (span * `EFOM_MID_NUM) / `EFOM_MID_DEN;
      mid_cur = lo + span[15:0];
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   efom_pkg::efom_err_t errsel;
   efom_pkg::efom_map_t errmap;
   efom_pkg::efom_fb_t  fbmode;
   logic [27:0]         funcmap;
   efom_pkg::efom_amp_t thr1;
   efom_pkg::efom_amp_t thr2;
   logic [1:0]          thrdir;
   efom_pkg::efom_err_t errstat;
   efom_pkg::efom_err_t funcstat;
   efom_pkg::efom_err_t irqstat;
   efom_pkg::efom_err_t irqen;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   wire        bus_req;
   wire        wr;
   wire [31:0] rd_word;
   wire        hit_errsel;
   wire        hit_errmap;
   wire        hit_fbmode;
   wire        hit_funcmap;
   wire        hit_thr1;
   wire        hit_thr2;
   wire        hit_thrdir;
   wire        hit_irqclr;
   wire        hit_irqen;

   assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr          = bus_req & wb_we_i;
   assign hit_errsel  = wb_adr_i == `EFOM_ERRSEL_OFS;
   assign hit_errmap  = wb_adr_i == `EFOM_ERRMAP_OFS;
   assign hit_fbmode  = wb_adr_i == `EFOM_FBMODE_OFS;
   assign hit_funcmap = wb_adr_i == `EFOM_FUNCMAP_OFS;
   assign hit_thr1    = wb_adr_i == `EFOM_THR1_OFS;
   assign hit_thr2    = wb_adr_i == `EFOM_THR2_OFS;
   assign hit_thrdir  = wb_adr_i == `EFOM_THRDIR_OFS;
   assign hit_irqclr  = wb_adr_i == `EFOM_IRQCLR_OFS;
   assign hit_irqen   = wb_adr_i == `EFOM_IRQEN_OFS;

   // Unmapped and write-only addresses read as zero.
   assign rd_word =
      hit_errsel                        ? {25'h0, errsel}       :
      hit_errmap                        ? {28'h0, errmap}       :
      hit_fbmode                        ? {30'h0, fbmode}       :
      hit_funcmap                       ? {4'h0, funcmap}       :
      hit_thr1                          ? {16'h0, thr1}         :
      hit_thr2                          ? {16'h0, thr2}         :
      hit_thrdir                        ? {30'h0, thrdir}       :
      hit_irqen                         ? {25'h0, irqen}        :
      wb_adr_i == `EFOM_ERRSTAT_OFS     ? {25'h0, errstat}      :
      wb_adr_i == `EFOM_FUNCSTAT_OFS    ? {25'h0, funcstat}     :
      wb_adr_i == `EFOM_IRQSTAT_OFS     ? {25'h0, irqstat}      :
      wb_adr_i == `EFOM_CHSTAT_OFS      ? {27'h0, fallback_o, ch_rdy_o, ch_err_o} :
      32'h00000000;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_word : 32'h00000000;
      end
   end

   wire [31:0] wv_errsel;
   wire [31:0] wv_errmap;
   wire [31:0] wv_fbmode;
   wire [31:0] wv_funcmap;
   wire [31:0] wv_thr1;
   wire [31:0] wv_thr2;
   wire [31:0] wv_thrdir;
   wire [31:0] wv_irqen;
   wire [31:0] wv_irqclr;

   assign wv_errsel  = merge({25'h0, errsel}, wb_dat_i, wb_sel_i);
   assign wv_errmap  = merge({28'h0, errmap}, wb_dat_i, wb_sel_i);
   assign wv_fbmode  = merge({30'h0, fbmode}, wb_dat_i, wb_sel_i);
   assign wv_funcmap = merge({4'h0, funcmap}, wb_dat_i, wb_sel_i);
   assign wv_thr1    = merge({16'h0, thr1}, wb_dat_i, wb_sel_i);
   assign wv_thr2    = merge({16'h0, thr2}, wb_dat_i, wb_sel_i);
   assign wv_thrdir  = merge({30'h0, thrdir}, wb_dat_i, wb_sel_i);
   assign wv_irqen   = merge({25'h0, irqen}, wb_dat_i, wb_sel_i);
   assign wv_irqclr  = merge(32'h00000000, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         errsel  <= `EFOM_ERRSEL_RST;
         errmap  <= `EFOM_ERRMAP_RST;
         fbmode  <= efom_pkg::FB_OFF;
         funcmap <= `EFOM_FUNCMAP_RST;
         thr1    <= `EFOM_THR_RST;
         thr2    <= `EFOM_THR_RST;
         thrdir  <= `EFOM_THRDIR_RST;
         irqen   <= `EFOM_IRQEN_RST;
      end else if (wr) begin
         if (hit_errsel)  errsel  <= wv_errsel[6:0];
         if (hit_errmap)  errmap  <= wv_errmap[3:0];
         if (hit_fbmode)  fbmode  <= efom_pkg::efom_fb_t'(wv_fbmode[1:0]);
         if (hit_funcmap) funcmap <= wv_funcmap[27:0];
         if (hit_thr1)    thr1    <= wv_thr1[15:0];
         if (hit_thr2)    thr2    <= wv_thr2[15:0];
         if (hit_thrdir)  thrdir  <= wv_thrdir[1:0];
         if (hit_irqen)   irqen   <= wv_irqen[6:0];
      end
   end

   // ----------------------------------------------------------------
   // Error collection
   // ----------------------------------------------------------------
   efom_pkg::efom_err_t err_live;
   wire                 brk;
   wire                 sc;

   always_comb begin
      err_live                = 7'h00;
      err_live[`EFOM_E_CMDBRK] = cmd_break_i;
      err_live[`EFOM_E_OPEN1]  = coil1_i.open;
      err_live[`EFOM_E_OPEN2]  = coil2_i.open;
      err_live[`EFOM_E_SC1]    = coil1_i.short_cct;
      err_live[`EFOM_E_SC2]    = coil2_i.short_cct;
      err_live[`EFOM_E_DEV]    = supply_fault_i | bus_fault_i;
      err_live[`EFOM_E_THR]    = thr_err_i;
   end

   assign brk = err_live[`EFOM_E_CMDBRK] | err_live[`EFOM_E_OPEN1] | err_live[`EFOM_E_OPEN2];
   assign sc  = err_live[`EFOM_E_SC1] | err_live[`EFOM_E_SC2];

   // ----------------------------------------------------------------
   // Fallback drive
   // ----------------------------------------------------------------
   efom_pkg::efom_amp_t mid1;
   efom_pkg::efom_amp_t mid2;
   efom_pkg::efom_amp_t next_cur1;
   efom_pkg::efom_amp_t next_cur2;
   wire                 fb_on1;
   wire                 fb_on2;

   assign mid1   = mid_cur(coil1_i.imin, coil1_i.imax);
   assign mid2   = mid_cur(coil2_i.imin, coil2_i.imax);
   assign fb_on1 = fbmode == efom_pkg::FB_SOL1 || fbmode == efom_pkg::FB_BOTH;
   assign fb_on2 = fbmode == efom_pkg::FB_SOL2 || fbmode == efom_pkg::FB_BOTH;

   // A short overrides every cable-break choice, since driving a shorted coil is unsafe.
   assign next_cur1 = sc  ? 16'h0000 :
                      brk ? (fb_on1 ? mid1 : 16'h0000) :
                      coil1_i.drive;
   assign next_cur2 = sc  ? 16'h0000 :
                      brk ? (fb_on2 ? mid2 : 16'h0000) :
                      coil2_i.drive;

   // ----------------------------------------------------------------
   // Function flags
   // ----------------------------------------------------------------
   efom_pkg::efom_err_t next_func;
   wire                 beyond1;
   wire                 beyond2;

   efom_thresh u_thr1 (
      .sig_i    (thr_sig1_i),
      .level_i  (thr1),
      .rise_i   (thrdir[0]),
      .beyond_o (beyond1)
   );

   efom_thresh u_thr2 (
      .sig_i    (thr_sig2_i),
      .level_i  (thr2),
      .rise_i   (thrdir[1]),
      .beyond_o (beyond2)
   );

   always_comb begin
      next_func                = 7'h00;
      next_func[`EFOM_F_SOL1]  = next_cur1 != 16'h0000;
      next_func[`EFOM_F_SOL2]  = next_cur2 != 16'h0000;
      next_func[`EFOM_F_READY] = err_live == 7'h00;
      next_func[`EFOM_F_CMD2]  = cmd2_sel_i;
      next_func[`EFOM_F_THR1]  = beyond1;
      next_func[`EFOM_F_THR2]  = beyond2;
      next_func[`EFOM_F_CTL2]  = coil1_i.use_other | coil2_i.use_other;
   end

   // ----------------------------------------------------------------
   // Output routing
   // ----------------------------------------------------------------
   wire        err_hit;
   logic [7:0] next_route;

   assign err_hit = |(err_live & errsel);

   // An index at or above N_DOUT selects no pin.
   always_comb begin
      next_route = route(errmap, err_hit);
      for (int k = 0; k < 7; k++) begin
         next_route = next_route | route(funcmap[k*4 +: 4], next_func[k]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         coil1_cur_o <= 16'h0000;
         coil2_cur_o <= 16'h0000;
         fallback_o  <= 1'b0;
         ch_err_o    <= 2'b00;
         ch_rdy_o    <= 2'b11;
         dout_o      <= '0;
         errstat     <= 7'h00;
         funcstat    <= 7'h00;
      end else begin
         coil1_cur_o <= next_cur1;
         coil2_cur_o <= next_cur2;
         fallback_o  <= brk | sc;
         ch_err_o[0] <= |(err_live & `EFOM_CH1_MASK);
         ch_err_o[1] <= |(err_live & `EFOM_CH2_MASK);
         ch_rdy_o[0] <= ~|(err_live & `EFOM_CH1_MASK);
         ch_rdy_o[1] <= ~|(err_live & `EFOM_CH2_MASK);
         dout_o      <= next_route[N_DOUT-1:0];
         errstat     <= err_live;
         funcstat    <= next_func;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   efom_pkg::efom_err_t rise;
   efom_pkg::efom_err_t clr;

   assign rise  = err_live & ~errstat;
   assign clr   = (wr && hit_irqclr) ? wv_irqclr[6:0] : 7'h00;
   assign irq_o = |(irqstat & irqen);

   // A new event in the cycle of its clear keeps the bit set.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irqstat <= 7'h00;
      end else begin
         irqstat <= (irqstat & ~clr) | rise;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence seq_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence seq_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   chk_bus_ack:
      assert property (seq_bus_req |=> seq_ack_pulse)
      else $error("Bus request not answered by a one-cycle ack.");

   chk_err_stat:
      assert property (##1 errstat == $past(err_live))
      else $error("Error status does not follow the live errors.");

   chk_dev_err:
      assert property ((supply_fault_i || bus_fault_i) |=> errstat[`EFOM_E_DEV])
      else $error("Supply or fieldbus fault missing from device error.");

   chk_short_off:
      assert property (sc |=> coil1_cur_o == 16'h0000 && coil2_cur_o == 16'h0000)
      else $error("Coil still driven after a short circuit.");

   chk_fb_mid:
      assert property (brk && !sc && fbmode == efom_pkg::FB_BOTH
                       |=> coil1_cur_o == $past(mid1) && coil2_cur_o == $past(mid2))
      else $error("Fallback current is not two thirds of the range.");

   chk_fb_off:
      assert property (brk && fbmode == efom_pkg::FB_OFF |=> coil1_cur_o == 16'h0000)
      else $error("Coil driven although fallback is off.");

   chk_err_out:
      assert property (err_hit && errmap[`EFOM_MAP_USED] && errmap[2:0] == 3'h0
                       |=> dout_o[0])
      else $error("Error output not active for an enabled error.");

   chk_no_route:
      assert property (!errmap[`EFOM_MAP_USED] && funcmap == 28'h0000000
                       |=> dout_o == '0)
      else $error("Output driven with nothing assigned.");

   chk_ch_ready:
      assert property (|(err_live & `EFOM_CH1_MASK) |=> ch_err_o[0] && !ch_rdy_o[0])
      else $error("Channel one does not show its error.");

   chk_sol_flag:
      assert property (funcstat[`EFOM_F_SOL1] == (coil1_cur_o != 16'h0000))
      else $error("Coil one active flag disagrees with its drive.");

   chk_cmd2_flag:
      assert property (cmd2_sel_i |=> funcstat[`EFOM_F_CMD2])
      else $error("Second command flag missing.");

   chk_thr_flag:
      assert property (thrdir[0] && thr_sig1_i > thr1 |=> funcstat[`EFOM_F_THR1])
      else $error("Threshold one flag missing above its level.");

   chk_irq_level:
      assert property (|(rise & irqen) && !(wr && hit_irqen)
                       |=> irq_o ##1 (irq_o || $past(wr && (hit_irqen || hit_irqclr))))
      else $error("Enabled event did not hold the interrupt.");

endmodule

/* verification/efom_coil_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Solenoid driver stage model
// ----------------------------------------------------------------
// The driver reports its fault flags, control-source swap and the
// current settings. The bench changes them just after a clock edge, so
// the model passes them straight through.
module efom_coil_model (
   input  wire logic                flt_i,
   input  wire logic                shrt_i,
   input  wire logic                swap_i,
   input  wire efom_pkg::efom_amp_t drv_i,
   input  wire efom_pkg::efom_amp_t imin_i,
   input  wire efom_pkg::efom_amp_t imax_i,
   output efom_pkg::efom_coil_t     coil_o
);
   assign coil_o = {flt_i, shrt_i, swap_i, drv_i, imin_i, imax_i};
endmodule

/* verification/efom_tb_top.sv */
`timescale 1ns/1ps
`include "efom_cfg.svh"

module efom_tb_top;
   localparam int ND = 6;
   logic                 clk_i = 1'b0;
   logic                 nrst_i = 1'b0;
   logic [7:0]           adr = 8'h00;
   logic [31:0]          wdat = 32'h0, rdat, rd;
   logic                 we = 1'b0, cyc = 1'b0, brk = 1'b0, sup = 1'b0, bflt = 1'b0;
   logic                 terr = 1'b0, cmd2 = 1'b0, ack, fbo, irq, fbk, r;
   logic [2:0]           flt [2] = '{default: '0};
   efom_pkg::efom_amp_t  drv [2] = '{default: '0};
   efom_pkg::efom_amp_t  lo [2] = '{default: '0};
   efom_pkg::efom_amp_t  hi [2] = '{default: '0};
   efom_pkg::efom_amp_t  sig [2] = '{default: '0};
   efom_pkg::efom_amp_t  th [2], x [2], cur [2];
   efom_pkg::efom_coil_t coil [2];
   logic [1:0]           cerr, crdy, ce, fb, dir;
   logic [ND-1:0]        dout, p;
   logic [6:0]           e, sel, en, f, clr, ep = 7'h00, st = 7'h00;
   logic [3:0]           em;
   logic [27:0]          fm;
   int                   seed = 32'h6c1a;
   int                   err_count = 0;
   int                   n_checks = 0;

   always #2.5 clk_i = ~clk_i;

   for (genvar k = 0; k < 2; k++) begin : g_coil
      efom_coil_model u_coil (.flt_i(flt[k][2]), .shrt_i(flt[k][1]), .swap_i(flt[k][0]),
                              .drv_i(drv[k]), .imin_i(lo[k]), .imax_i(hi[k]),
                              .coil_o(coil[k]));
   end

   efom_top #(.N_DOUT(ND)) uut (
      .clk_i(clk_i), .nrst_i(nrst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cmd_break_i(brk), .coil1_i(coil[0]), .coil2_i(coil[1]), .supply_fault_i(sup),
      .bus_fault_i(bflt), .thr_err_i(terr), .cmd2_sel_i(cmd2), .thr_sig1_i(sig[0]),
      .thr_sig2_i(sig[1]), .coil1_cur_o(cur[0]), .coil2_cur_o(cur[1]),
      .fallback_o(fbo), .ch_err_o(cerr), .ch_rdy_o(crdy), .dout_o(dout), .irq_o(irq));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic efom_pkg::efom_amp_t mid(input logic [15:0] l, input logic [15:0] h);
      if (h < l) begin
         return l;
      end
      return l + 16'((18'(h - l) * 18'h00002) / 18'h00003);
   endfunction

   // A pin index at or above the output count drives nothing.
   function automatic logic [ND-1:0] pin(input logic [3:0] m, input logic a,
                                         input logic [ND-1:0] q);
      if (m[3] && a && m[2:0] < ND) begin
         q[m[2:0]] = 1'b1;
      end
      return q;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits for the answer as long as it takes; only the watchdog ends a hang.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task automatic finish_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      chk(crdy, 32'h3);
      chk(cerr, 32'h0);
      chk(dout, 32'h0);
      rchk(`EFOM_ERRSEL_OFS, 32'h7f);
      rchk(`EFOM_THR1_OFS, 32'h8000);
      rchk(`EFOM_THRDIR_OFS, 32'h3);
      rchk(`EFOM_IRQCLR_OFS, 32'h0);
      rchk(8'h3c, 32'h0);
      for (int it = 0; it < 40; it++) begin
         e = 7'($random(seed) & $random(seed) & $random(seed));
         fb = 2'($random(seed));
         if (it < 2) begin
            e = it ? 7'h0a : 7'h08;
            fb = 2'h3;
         end
         for (int k = 0; k < 2; k++) begin
            drv[k] <= ($random(seed) & 1) ? 16'($random(seed)) : 16'h0000;
            lo[k] <= 16'($random(seed));
            hi[k] <= 16'($random(seed));
            sig[k] <= 16'($random(seed));
            th[k] = 16'($random(seed));
            flt[k] <= {e[3+k], e[1+k], &2'($random(seed))};
         end
         if (it < 2) begin
            lo[0] <= 16'h0064;
            hi[0] <= 16'h02bc;
         end
         sel = 7'($random(seed));
         en = 7'($random(seed));
         em = 4'($random(seed));
         fm = 28'($random(seed));
         dir = 2'($random(seed));
         if (it < 2) begin
            em = 4'h8;
            sel = 7'h7f;
         end
         r = 1'($random(seed));
         cmd2 <= 1'($random(seed));
         brk <= e[0];
         terr <= e[6];
         sup <= e[5] & r;
         bflt <= e[5] & ~r;
         bus(`EFOM_ERRSEL_OFS, 1'b1, 32'(sel));
         bus(`EFOM_ERRMAP_OFS, 1'b1, 32'(em));
         bus(`EFOM_FBMODE_OFS, 1'b1, 32'(fb));
         bus(`EFOM_FUNCMAP_OFS, 1'b1, 32'(fm));
         bus(`EFOM_THR1_OFS, 1'b1, 32'(th[0]));
         bus(`EFOM_THR2_OFS, 1'b1, 32'(th[1]));
         bus(`EFOM_THRDIR_OFS, 1'b1, 32'(dir));
         bus(`EFOM_IRQEN_OFS, 1'b1, 32'(en));
         fbk = |e[4:0];
         ce = {|(e & `EFOM_CH2_MASK), |(e & `EFOM_CH1_MASK)};
         for (int k = 0; k < 2; k++) begin
            x[k] = !fbk ? drv[k] : (e[2:1] == 2'h0 && fb[k]) ? mid(lo[k], hi[k]) : 16'h0000;
            f[k] = x[k] != 16'h0000;
            f[4+k] = dir[k] ? sig[k] > th[k] : sig[k] < th[k];
         end
         f[2] = ~|e;
         f[3] = cmd2;
         f[6] = coil[0].use_other | coil[1].use_other;
         p = pin(em, |(e & sel), '0);
         for (int j = 0; j < 7; j++) begin
            p = pin(fm[4*j +: 4], f[j], p);
         end
         chk(cur[0], x[0]);
         chk(cur[1], x[1]);
         if (it < 2) begin
            chk(cur[0], it ? 32'h0 : 32'h01f4);
         end
         chk(fbo, fbk);
         chk(cerr, ce);
         chk(crdy, {~ce});
         chk(dout, p);
         rchk(`EFOM_ERRSTAT_OFS, e);
         rchk(`EFOM_FUNCSTAT_OFS, f);
         rchk(`EFOM_CHSTAT_OFS, {fbk, ~ce, ce});
         st = st | (e & ~ep);
         ep = e;
         rchk(`EFOM_IRQSTAT_OFS, st);
         clr = 7'($random(seed));
         bus(`EFOM_IRQCLR_OFS, 1'b1, 32'(clr));
         st = st & ~clr;
         rchk(`EFOM_IRQSTAT_OFS, st);
         chk(irq, |(st & en));
      end
      finish_test();
   end
endmodule
